//--- shared/exec_pkg.sv
// constants for the set-all-ones and power-down execution block
package exec_pkg;
  // opcode patterns
  localparam logic [6:0] SET_ALL_OP = 7'h34;
  localparam int SET_ALL_OP_LSB = 9;
  localparam int BANK_FLAG_BIT = 8;
  localparam logic [15:0] SLEEP_OP = 16'h0003;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  // register map (byte addresses)
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] BANK_OFS = 4'h4;
  localparam logic [3:0] STATUS_OFS = 4'h8;
  localparam int CTRL_EXT_BIT = 0;
  localparam int STATUS_TIMEOUT_BIT = 0;
  localparam int STATUS_PDOWN_BIT = 1;
  localparam int STATUS_SLEEP_BIT = 2;
  localparam logic CTRL_EXT_RESET = 1'b0;
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam logic TIMEOUT_RESET = 1'b1;
  localparam logic PDOWN_RESET = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- shared/decode_if.sv
// carrier between the executing core and its opcode decoder
interface decode_if;
  logic [15:0] instr;
  logic ext_en;
  logic [3:0] bank_select_reg;
  logic [11:0] index_base;
  logic is_set_all;
  logic is_sleep;
  logic [11:0] file_addr;
  modport dec (input instr, ext_en, bank_select_reg, index_base,
               output is_set_all, is_sleep, file_addr);
  modport core (output instr, ext_en, bank_select_reg, index_base,
                input is_set_all, is_sleep, file_addr);
endinterface

//--- hdl/opcode_decoder.sv
// opcode decoder and file address resolution
module opcode_decoder (
  decode_if.dec d
);
  logic [7:0] f;
  logic bank_flag;

  assign f = d.instr[7:0];
  assign bank_flag = d.instr[exec_pkg::BANK_FLAG_BIT];
  assign d.is_set_all = d.instr[15:exec_pkg::SET_ALL_OP_LSB] == exec_pkg::SET_ALL_OP;
  assign d.is_sleep = d.instr == exec_pkg::SLEEP_OP;

  always_comb begin
    if (bank_flag) begin
      d.file_addr = {d.bank_select_reg, f};
    end else if (d.ext_en && f <= exec_pkg::INDEXED_LIMIT) begin
      d.file_addr = 12'(d.index_base + {4'h0, f});
    end else if (f >= exec_pkg::ACCESS_SPLIT) begin
      d.file_addr = {exec_pkg::ACCESS_HIGH_BANK, f};
    end else begin
      d.file_addr = {exec_pkg::ACCESS_LOW_BANK, f};
    end
  end
endmodule

//--- hdl/set_file_and_power_down_exec.sv
// executes the set-all-ones and power-down instructions, with an axi4-lite register slave
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
module set_file_and_power_down_exec (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [11:0] index_base,
  input wire logic wake_watchdog,
  input wire logic wake_other,
  output logic file_wr_en,
  output logic [11:0] file_wr_addr,
  output logic [7:0] file_wr_data,
  output logic watchdog_clear,
  output logic osc_stop,
  output logic timeout_status_flag_n,
  output logic power_down_status_flag_n,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [31:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  typedef enum logic {RUN, ASLEEP} core_state_e;

  core_state_e state;
  logic ext_en;
  logic [3:0] bank_select_reg;
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic exec_ok;
  logic exec_set_all;
  logic exec_sleep;

  // the decoder sits behind an interface so the address resolution can be
  // swapped without touching the execution logic below
  decode_if dif ();

  assign dif.instr = instr_word;
  assign dif.ext_en = ext_en;
  assign dif.bank_select_reg = bank_select_reg;
  assign dif.index_base = index_base;

  opcode_decoder u_dec (
    .d(dif.dec)
  );

  // no instruction is accepted while asleep: the oscillator is stopped
  assign exec_ok = instr_valid && state == RUN;
  // both opcodes are decoded from the same word; they can never match together
  assign exec_set_all = exec_ok && dif.is_set_all;
  assign exec_sleep = exec_ok && dif.is_sleep;

  // core state
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= RUN;
    end else begin
      unique case (state)
        RUN: begin
          if (exec_sleep) begin
            state <= ASLEEP;
          end
        end
        ASLEEP: begin
          if (wake_watchdog || wake_other) begin
            state <= RUN;
          end
        end
      endcase
    end
  end

  // osc_stop mirrors the asleep state; it is kept as its own flop so the
  // output comes straight from a register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      osc_stop <= 1'b0;
    end else if (exec_sleep) begin
      osc_stop <= 1'b1;
    end else if (state == ASLEEP && (wake_watchdog || wake_other)) begin
      osc_stop <= 1'b0;
    end
  end

  // file write port; only the data byte is driven, no status flag path exists
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      file_wr_en <= 1'b0;
      file_wr_addr <= 12'h000;
      file_wr_data <= 8'h00;
    end else begin
      file_wr_en <= exec_set_all;
      // address and data hold between writes so a slow file can sample late
      if (exec_set_all) begin
        file_wr_addr <= dif.file_addr;
        file_wr_data <= exec_pkg::ALL_ONES;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      watchdog_clear <= 1'b0;
    end else begin
      watchdog_clear <= exec_sleep;
    end
  end

  // status flags
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      power_down_status_flag_n <= exec_pkg::PDOWN_RESET;
    end else if (exec_sleep) begin
      power_down_status_flag_n <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      timeout_status_flag_n <= exec_pkg::TIMEOUT_RESET;
    end else if (exec_sleep) begin
      timeout_status_flag_n <= 1'b1;
    end else if (state == ASLEEP && wake_watchdog) begin
      timeout_status_flag_n <= 1'b0;
    end
  end

  // axi4-lite write side: address and data taken in either order
  // limitation: only one write is in flight; readies stay low until the
  // response has been taken, trading throughput for a tiny slave
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr[3:0];
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // ready is registered so each channel takes one beat per write
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= exec_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr == exec_pkg::CTRL_OFS || aw_addr == exec_pkg::BANK_OFS ||
          aw_addr == exec_pkg::STATUS_OFS) begin
        s_axi_bresp <= exec_pkg::RESP_OKAY;
      end else begin
        s_axi_bresp <= exec_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ext_en <= exec_pkg::CTRL_EXT_RESET;
      bank_select_reg <= exec_pkg::BANK_RESET;
    end else if (do_write && w_strb[0]) begin
      if (aw_addr == exec_pkg::CTRL_OFS) begin
        ext_en <= w_data[exec_pkg::CTRL_EXT_BIT];
      end
      if (aw_addr == exec_pkg::BANK_OFS) begin
        bank_select_reg <= w_data[3:0];
      end
    end
  end

  // axi4-lite read side
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= exec_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= exec_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      unique case (s_axi_araddr[3:0])
        exec_pkg::CTRL_OFS: s_axi_rdata[exec_pkg::CTRL_EXT_BIT] <= ext_en;
        exec_pkg::BANK_OFS: s_axi_rdata[3:0] <= bank_select_reg;
        exec_pkg::STATUS_OFS: begin
          s_axi_rdata[exec_pkg::STATUS_TIMEOUT_BIT] <= timeout_status_flag_n;
          s_axi_rdata[exec_pkg::STATUS_PDOWN_BIT] <= power_down_status_flag_n;
          s_axi_rdata[exec_pkg::STATUS_SLEEP_BIT] <= state == ASLEEP;
        end
        default: s_axi_rresp <= exec_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

//--- dv/set_file_and_power_down_exec_props.sv
// assertions on the instruction side of the block
module set_file_and_power_down_exec_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic wake_watchdog,
  input wire logic wake_other,
  input wire logic file_wr_en,
  input wire logic [7:0] file_wr_data,
  input wire logic watchdog_clear,
  input wire logic osc_stop,
  input wire logic timeout_status_flag_n,
  input wire logic power_down_status_flag_n
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  wire logic go = instr_valid && !osc_stop;
  wire logic set_all = go && instr_word[15:9] == exec_pkg::SET_ALL_OP;
  wire logic slp = go && instr_word == exec_pkg::SLEEP_OP;
  a_set_all_write: assert property (set_all |=> file_wr_en && file_wr_data == 8'hFF)
    else $error("set-all-ones write missing");
  a_no_stray_write: assert property (!set_all |=> !file_wr_en)
    else $error("write without set-all-ones");
  a_pd_cleared: assert property (slp |=> !power_down_status_flag_n)
    else $error("power-down flag not cleared");
  a_to_set: assert property (slp |=> timeout_status_flag_n)
    else $error("time-out flag not set");
  a_dog_pulse: assert property (slp |=> watchdog_clear ##1 !watchdog_clear)
    else $error("watchdog clear pulse wrong");
  a_osc_stops: assert property (slp |=> osc_stop)
    else $error("oscillator not stopped");
  a_asleep_idle: assert property (osc_stop |=> !file_wr_en && !watchdog_clear)
    else $error("instruction ran while asleep");
  a_dog_wake: assert property (osc_stop && wake_watchdog |=> !osc_stop && !timeout_status_flag_n)
    else $error("watchdog wake wrong");
  a_other_wake: assert property (osc_stop && wake_other && !wake_watchdog
    |=> !osc_stop && $stable(timeout_status_flag_n))
    else $error("other wake wrong");
  c_set_all: cover property (set_all ##1 file_wr_en);
  c_sleep: cover property (slp ##1 osc_stop);
  c_dog_wake: cover property (osc_stop && wake_watchdog);
endmodule
bind set_file_and_power_down_exec set_file_and_power_down_exec_props u_props (.*);

//--- dv/set_file_and_power_down_exec_tb.sv
// self-checking bench for the set-all-ones and power-down block
module set_file_and_power_down_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst_n = 0, instr_valid = 0, wake_watchdog = 0, wake_other = 0;
  logic [15:0] instr_word = 16'h0000;
  logic [11:0] index_base = 12'hFF0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, file_wr_en, watchdog_clear, osc_stop;
  logic timeout_status_flag_n, power_down_status_flag_n;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [11:0] file_wr_addr;
  logic [7:0] file_wr_data;
  int n_errors = 0, compares = 0;
  set_file_and_power_down_exec u_set_file_and_power_down_exec (.*);
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask
  task automatic axi_rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk(32'(s_axi_rresp), 32'(er));
  endtask
  // one-cycle instruction; returns just after the edge that takes it has settled
  task automatic issue(input logic [15:0] w);
    @(posedge ref_clk);
    instr_word <= w;
    instr_valid <= 1'b1;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
  endtask
  task automatic set_all_chk(input logic [15:0] w, input logic [11:0] ea);
    issue(w);
    chk(32'(file_wr_en), 32'h1);
    chk(32'(file_wr_addr), 32'(ea));
    chk(32'(file_wr_data), 32'hFF);
  endtask
  task automatic t_regs;
    axi_rd(32'h0, 32'h0, 2'h0);
    axi_rd(32'h8, 32'h3, 2'h0);
    axi_rd(32'hC, 32'h0, 2'h2);
    axi_wr(32'hC, 32'h1, 2'h2);
    axi_wr(32'h4, 32'h5, 2'h0);
    axi_rd(32'h4, 32'h5, 2'h0);
    $display("regs test done");
  endtask
  task automatic t_set_all;
    set_all_chk(16'h6912, 12'h512);
    @(posedge ref_clk);
    #1;
    chk(32'(file_wr_en), 32'h0);
    set_all_chk(16'h68A5, 12'hFA5);
    set_all_chk(16'h6820, 12'h020);
    axi_wr(32'h0, 32'h1, 2'h0);
    // base plus offset wraps past the top of the 12-bit space
    set_all_chk(16'h685F, 12'h04F);
    set_all_chk(16'h6860, 12'hF60);
    issue(16'h0004);
    chk(32'(file_wr_en), 32'h0);
    axi_rd(32'h8, 32'h3, 2'h0);
    $display("set-all-ones test done");
  endtask
  task automatic t_sleep(input bit by_dog);
    issue(16'h0003);
    chk(32'(watchdog_clear), 32'h1);
    chk(32'(osc_stop), 32'h1);
    chk(32'(power_down_status_flag_n), 32'h0);
    chk(32'(timeout_status_flag_n), 32'h1);
    issue(16'h6912);
    chk(32'(file_wr_en), 32'h0);
    chk(32'(watchdog_clear), 32'h0);
    @(posedge ref_clk);
    wake_watchdog <= by_dog;
    wake_other <= !by_dog;
    @(posedge ref_clk);
    wake_watchdog <= 1'b0;
    wake_other <= 1'b0;
    #1;
    chk(32'(osc_stop), 32'h0);
    chk(32'(timeout_status_flag_n), 32'(!by_dog));
    $display("power-down test done");
  endtask
  task automatic wrap_up;
    $display("compares=%0d errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs;
    t_set_all;
    // watchdog wake first, so the second power-down must raise the time-out flag again
    t_sleep(1'b1);
    t_sleep(1'b0);
    wrap_up;
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_errors++;
    wrap_up;
  end
endmodule
